// ===== hw/startup_open_loop_config.sv
// Start-up configuration register bank and open-loop ramp sequencer
//
// How it works
// - 32-bit config at index 86h, byte 218h, resets to zero, all RW.
// - Bits 30-27 code the open-loop current cap, 0.078125 A to 3.75 A.
// - Bits 26-23 code the linear ramp coefficient, 0.01 to 10000 Hz/s.
// - Bits 22-19 code the quadratic coefficient, 0 to 10000 Hz/s2.
// - Bit 18 set gives automatic handoff; clear uses the speed threshold.
// - Bits 17-13 give threshold 1-20% by 1%, then 22.5-50% by 2.5%.
// - Coded cap applies only when source select is zero, else general cap.
// - Bit 3 picks first-cycle frequency: zero, or the coded percentage.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "startup_regs.svh"

module startup_open_loop_config
  import startup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = `TICK_CYCLES,
  parameter int unsigned MAX_SPEED_HZ = `MAX_SPEED_HZ
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST_N,
  input  wire logic [11:0] I_AXI_AWADDR,
  input  wire logic        I_AXI_AWVALID,
  output logic             O_AXI_AWREADY,
  input  wire logic [31:0] I_AXI_WDATA,
  input  wire logic [3:0]  I_AXI_WSTRB,
  input  wire logic        I_AXI_WVALID,
  output logic             O_AXI_WREADY,
  output logic [1:0]       O_AXI_BRESP,
  output logic             O_AXI_BVALID,
  input  wire logic        I_AXI_BREADY,
  input  wire logic [11:0] I_AXI_ARADDR,
  input  wire logic        I_AXI_ARVALID,
  output logic             O_AXI_ARREADY,
  output logic [31:0]      O_AXI_RDATA,
  output logic [1:0]       O_AXI_RRESP,
  output logic             O_AXI_RVALID,
  input  wire logic        I_AXI_RREADY,
  input  wire logic        I_OBSERVER_LOCK,
  output logic             O_OPEN_LOOP,
  output logic             O_CLOSED_LOOP,
  output logic [7:0]       O_CURRENT_LIMIT,
  output logic [31:0]      O_ELEC_FREQ
);

  // ---------------------------------------------------------------
  // Lookup and helper functions
  // ---------------------------------------------------------------
  // Ramp coefficient times 100; linear code 0 is 0.01, quadratic 0.0
  function automatic logic [19:0] coeff_x100(input logic [3:0] code,
                                             input logic       quad);
    case (code)
      4'h0:    coeff_x100 = quad ? 20'h0 : 20'h1;
      4'h1:    coeff_x100 = 20'h5;
      4'h2:    coeff_x100 = 20'h64;
      4'h3:    coeff_x100 = 20'hfa;
      4'h4:    coeff_x100 = 20'h1f4;
      4'h5:    coeff_x100 = 20'h3e8;
      4'h6:    coeff_x100 = 20'h9c4;
      4'h7:    coeff_x100 = 20'h1388;
      4'h8:    coeff_x100 = 20'h1d4c;
      4'h9:    coeff_x100 = 20'h2710;
      4'ha:    coeff_x100 = 20'h61a8;
      4'hb:    coeff_x100 = 20'hc350;
      4'hc:    coeff_x100 = 20'h124f8;
      4'hd:    coeff_x100 = 20'h186a0;
      4'he:    coeff_x100 = 20'h7a120;
      default: coeff_x100 = 20'hf4240;
    endcase
  endfunction

  // Percent of maximum speed, in tenths of a percent
  function automatic logic [9:0] icf_permille(input logic [3:0] code);
    case (code)
      4'h0:    icf_permille = 10'h00a;
      4'h1:    icf_permille = 10'h014;
      4'h2:    icf_permille = 10'h01e;
      4'h3:    icf_permille = 10'h032;
      4'h4:    icf_permille = 10'h04b;
      4'h5:    icf_permille = 10'h064;
      4'h6:    icf_permille = 10'h07d;
      4'h7:    icf_permille = 10'h096;
      4'h8:    icf_permille = 10'h0af;
      4'h9:    icf_permille = 10'h0c8;
      4'ha:    icf_permille = 10'h0fa;
      4'hb:    icf_permille = 10'h12c;
      4'hc:    icf_permille = 10'h15e;
      4'hd:    icf_permille = 10'h190;
      4'he:    icf_permille = 10'h1c2;
      default: icf_permille = 10'h1f4;
    endcase
  endfunction

  // Frequency in 1e-8 Hz for a fraction of maximum speed
  function automatic logic [47:0] speed_frac(input logic [9:0] permille);
    speed_frac = 48'(MAX_SPEED_HZ) * 48'(permille) * 48'd100000;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  logic [31:0]  startup2_q;
  logic [31:0]  ctrl_q;
  logic [11:0]  awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         aw_held_q;
  logic         w_held_q;
  logic         do_write;
  seq_state_t   state_q;
  logic [47:0]  freq_q;
  logic [47:0]  rate_q;

  assign do_write = aw_held_q && w_held_q && !O_AXI_BVALID;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      O_AXI_AWREADY <= 1'b0;
      O_AXI_WREADY  <= 1'b0;
      O_AXI_BVALID  <= 1'b0;
      O_AXI_BRESP   <= `RESP_OKAY;
    end else begin
      O_AXI_AWREADY <= !aw_held_q && !O_AXI_AWREADY;
      O_AXI_WREADY  <= !w_held_q && !O_AXI_WREADY;
      if (I_AXI_AWVALID && O_AXI_AWREADY) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= I_AXI_AWADDR;
        O_AXI_AWREADY <= 1'b0;
      end
      if (I_AXI_WVALID && O_AXI_WREADY) begin
        w_held_q     <= 1'b1;
        wdata_q      <= I_AXI_WDATA;
        wstrb_q      <= I_AXI_WSTRB;
        O_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        O_AXI_BVALID <= 1'b1;
        O_AXI_BRESP  <= (awaddr_q == `STARTUP2_ADDR ||
                         awaddr_q == `CTRL_ADDR) ? `RESP_OKAY
                                                 : `RESP_SLVERR;
      end else if (O_AXI_BVALID && I_AXI_BREADY) begin
        O_AXI_BVALID <= 1'b0;
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
      end
    end
  end

  // Writable registers
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      startup2_q <= `STARTUP2_RESET;
      ctrl_q     <= `CTRL_RESET;
    end else if (do_write) begin
      if (awaddr_q == `STARTUP2_ADDR) begin
        startup2_q <= merge(startup2_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == `CTRL_ADDR) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
      end
    end
  end

  // Read channel: one read at a time, data one cycle after address
  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_AXI_ARREADY <= 1'b0;
      O_AXI_RVALID  <= 1'b0;
      O_AXI_RDATA   <= '0;
      O_AXI_RRESP   <= `RESP_OKAY;
    end else if (O_AXI_RVALID) begin
      if (I_AXI_RREADY) begin
        O_AXI_RVALID <= 1'b0;
      end
    end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
      O_AXI_ARREADY <= 1'b0;
      O_AXI_RVALID  <= 1'b1;
      O_AXI_RRESP   <= `RESP_OKAY;
      case (I_AXI_ARADDR)
        `STARTUP2_ADDR: O_AXI_RDATA <= startup2_q;
        `CTRL_ADDR:     O_AXI_RDATA <= ctrl_q;
        `STATUS_ADDR:   O_AXI_RDATA <= {30'h0, state_q};
        `FREQ_ADDR:     O_AXI_RDATA <= freq_q[47:16];
        default: begin
          O_AXI_RDATA <= '0;
          O_AXI_RRESP <= `RESP_SLVERR;
        end
      endcase
    end else begin
      O_AXI_ARREADY <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Field extraction
  // ---------------------------------------------------------------
  startup_cfg_t cfg;
  logic [4:0]   thr;
  logic [9:0]   thr_permille;
  logic [47:0]  thr_freq;
  logic [47:0]  init_freq;
  logic [47:0]  lin_step;
  logic [47:0]  quad_step;
  logic         handoff;
  logic         tick;

  always_comb begin
    cfg.cap_code     = startup2_q[`CAP_MSB:`CAP_LSB];
    cfg.lin_code     = startup2_q[`LIN_MSB:`LIN_LSB];
    cfg.quad_code    = startup2_q[`QUAD_MSB:`QUAD_LSB];
    cfg.auto_handoff = startup2_q[`AUTO_BIT];
    cfg.thr_code     = startup2_q[`THR_MSB:`THR_LSB];
    cfg.icf_code     = startup2_q[`ICF_MSB:`ICF_LSB];
    cfg.icf_sel      = startup2_q[`ICF_SEL_BIT];
  end

  // Threshold: 1% steps up to code 13h, then 2.5% steps
  assign thr          = cfg.thr_code;
  assign thr_permille = (thr < 5'h14) ? 10'(({5'h0, thr} + 10'h1) * 10'ha)
                        : 10'(10'hc8 + ({5'h0, thr} - 10'h13) * 10'h19);
  assign thr_freq     = speed_frac(thr_permille);
  assign init_freq    = cfg.icf_sel ? speed_frac(icf_permille(cfg.icf_code))
                                    : 48'h0;
  assign lin_step     = 48'(coeff_x100(cfg.lin_code, 1'b0)) * 48'd1000;
  assign quad_step    = 48'(coeff_x100(cfg.quad_code, 1'b1));
  assign handoff      = cfg.auto_handoff ? I_OBSERVER_LOCK
                                         : (freq_q >= thr_freq);

  // ---------------------------------------------------------------
  // Open-loop ramp sequencer
  // ---------------------------------------------------------------
  startup_tick_gen #(
    .PERIOD (TICK_CYCLES)
  ) u_tick (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_run   (state_q == ST_OPEN),
    .o_tick  (tick)
  );

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= ST_IDLE;
      freq_q  <= '0;
      rate_q  <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ctrl_q[`CTRL_RUN_BIT]) begin
            state_q <= ST_OPEN;
            freq_q  <= init_freq;
            rate_q  <= '0;
          end
        end
        ST_OPEN: begin
          if (!ctrl_q[`CTRL_RUN_BIT]) begin
            state_q <= ST_IDLE;
            freq_q  <= '0;
          end else if (handoff) begin
            state_q <= ST_CLOSED;
          end else if (tick) begin
            rate_q <= rate_q + quad_step;
            freq_q <= freq_q + lin_step + rate_q;
          end
        end
        ST_CLOSED: begin
          if (!ctrl_q[`CTRL_RUN_BIT]) begin
            state_q <= ST_IDLE;
            freq_q  <= '0;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  logic [7:0] coded_cap;

  // Cap in steps of 0.078125 A; reserved codes clamp to the top step
  always_comb begin
    case (cfg.cap_code)
      4'h0:    coded_cap = 8'h01;
      4'h1:    coded_cap = 8'h02;
      4'he,
      4'hf:    coded_cap = 8'h30;
      default: coded_cap = {2'b00, cfg.cap_code, 2'b00} - 8'h04;
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_OPEN_LOOP     <= 1'b0;
      O_CLOSED_LOOP   <= 1'b0;
      O_CURRENT_LIMIT <= '0;
      O_ELEC_FREQ     <= '0;
    end else begin
      O_OPEN_LOOP     <= (state_q == ST_OPEN);
      O_CLOSED_LOOP   <= (state_q == ST_CLOSED);
      O_CURRENT_LIMIT <= ctrl_q[`CTRL_SRC_BIT]
                         ? ctrl_q[`CTRL_GCAP_MSB:`CTRL_GCAP_LSB]
                         : coded_cap;
      O_ELEC_FREQ     <= freq_q[47:16];
    end
  end

endmodule // startup_open_loop_config

`default_nettype wire

// ===== hw/startup_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef STARTUP_REGS_SVH
`define STARTUP_REGS_SVH

// ---------------------------------------------------------------
// Register map (byte addresses on the AXI4-Lite bus)
// ---------------------------------------------------------------
`define STARTUP2_INDEX     12'h086
`define STARTUP2_ADDR      12'(`STARTUP2_INDEX * 4)
`define CTRL_ADDR          12'h300
`define STATUS_ADDR        12'h304
`define FREQ_ADDR          12'h308

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define STARTUP2_RESET     32'h0000_0000
`define CTRL_RESET         32'h0000_0000

// ---------------------------------------------------------------
// Start-up configuration fields
// ---------------------------------------------------------------
`define CAP_MSB            30
`define CAP_LSB            27
`define LIN_MSB            26
`define LIN_LSB            23
`define QUAD_MSB           22
`define QUAD_LSB           19
`define AUTO_BIT           18
`define THR_MSB            17
`define THR_LSB            13
`define ICF_MSB            7
`define ICF_LSB            4
`define ICF_SEL_BIT        3

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTRL_RUN_BIT       0
`define CTRL_SRC_BIT       1
`define CTRL_GCAP_MSB      15
`define CTRL_GCAP_LSB      8

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      8
`define TICK_TIME_NS       1000000
`define TICK_CYCLES        (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define MAX_SPEED_HZ       1000

// Response codes
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// ===== hw/startup_pkg.sv
// Types shared by the start-up sequencer files
package startup_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OPEN   = 2'b01,
    ST_CLOSED = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic [3:0] cap_code;
    logic [3:0] lin_code;
    logic [3:0] quad_code;
    logic       auto_handoff;
    logic [4:0] thr_code;
    logic [3:0] icf_code;
    logic       icf_sel;
  } startup_cfg_t;

endpackage

// ===== hw/startup_tick_gen.sv
// Ramp tick generator for the open-loop sequencer
`timescale 1ns/1ps
`default_nettype none

module startup_tick_gen #(
  parameter int unsigned PERIOD = 125000
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_run,
  output logic      o_tick
);

  localparam int unsigned CW = $clog2(PERIOD + 1);

  logic [CW-1:0] count_q;

  // ---------------------------------------------------------------
  // Counter restarts whenever the ramp is not running
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q <= '0;
      o_tick  <= 1'b0;
    end else if (!i_run) begin
      count_q <= '0;
      o_tick  <= 1'b0;
    end else if (count_q == CW'(PERIOD - 1)) begin
      count_q <= '0;
      o_tick  <= 1'b1;
    end else begin
      count_q <= count_q + 1'b1;
      o_tick  <= 1'b0;
    end
  end

endmodule // startup_tick_gen

`default_nettype wire

// ===== sim/startup_open_loop_config_properties.sv
// Port-level checker for the start-up configuration block
`timescale 1ns/1ps
`default_nettype none

module startup_open_loop_config_chk (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_AXI_AWVALID,
  input wire logic        O_AXI_AWREADY,
  input wire logic        I_AXI_WVALID,
  input wire logic        O_AXI_WREADY,
  input wire logic        O_AXI_BVALID,
  input wire logic        I_AXI_BREADY,
  input wire logic        I_AXI_ARVALID,
  input wire logic        O_AXI_ARREADY,
  input wire logic [31:0] O_AXI_RDATA,
  input wire logic        O_AXI_RVALID,
  input wire logic        I_AXI_RREADY,
  input wire logic        O_OPEN_LOOP,
  input wire logic        O_CLOSED_LOOP,
  input wire logic [31:0] O_ELEC_FREQ
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RST_N);

  // ---------------------------------------------------------------
  // Bus handshakes
  // ---------------------------------------------------------------
  sequence s_aw_take; I_AXI_AWVALID && O_AXI_AWREADY; endsequence
  sequence s_w_take;  I_AXI_WVALID && O_AXI_WREADY;   endsequence
  sequence s_b_wait;  O_AXI_BVALID && !I_AXI_BREADY;  endsequence

  property p_aw_refuse; s_aw_take |=> !O_AXI_AWREADY; endproperty
  property p_w_refuse;  s_w_take |=> !O_AXI_WREADY;   endproperty
  property p_b_answer;  s_aw_take and s_w_take |-> ##[1:2] O_AXI_BVALID;
  endproperty
  property p_b_hold;    s_b_wait |=> O_AXI_BVALID; endproperty
  property p_r_answer;
    I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID && !O_AXI_ARREADY;
  endproperty
  property p_r_hold;
    O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA);
  endproperty

  a_aw_refuse: assert property (p_aw_refuse) else $error("aw taken twice");
  a_w_refuse: assert property (p_w_refuse) else $error("w taken twice");
  a_b_answer: assert property (p_b_answer) else $error("no write resp");
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  a_r_answer: assert property (p_r_answer) else $error("no read data");
  a_r_hold: assert property (p_r_hold) else $error("rdata unstable");

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  property p_excl; !(O_OPEN_LOOP && O_CLOSED_LOOP); endproperty
  property p_close_from_open; $rose(O_CLOSED_LOOP) |-> $past(O_OPEN_LOOP);
  endproperty
  property p_closed_hold; O_CLOSED_LOOP [*3] |-> $stable(O_ELEC_FREQ);
  endproperty
  property p_open_rises;
    O_OPEN_LOOP [*2] |-> O_ELEC_FREQ >= $past(O_ELEC_FREQ);
  endproperty

  a_excl: assert property (p_excl) else $error("open and closed");
  a_close_from_open: assert property (p_close_from_open) else $error("bad close");
  a_closed_hold: assert property (p_closed_hold) else $error("freq moved");
  a_open_rises: assert property (p_open_rises) else $error("freq fell");
endmodule // startup_open_loop_config_chk

bind startup_open_loop_config startup_open_loop_config_chk u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N),
  .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY),
  .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY),
  .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
  .I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY),
  .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RVALID(O_AXI_RVALID),
  .I_AXI_RREADY(I_AXI_RREADY), .O_OPEN_LOOP(O_OPEN_LOOP),
  .O_CLOSED_LOOP(O_CLOSED_LOOP), .O_ELEC_FREQ(O_ELEC_FREQ));

`default_nettype wire

// ===== sim/startup_open_loop_config_tb_top.sv
// Self-checking bench for the start-up configuration block
`timescale 1ns/1ps
`default_nettype none
`include "startup_regs.svh"

`define CHK(nm, e, a) begin compares++; \
  if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end

module startup_open_loop_config_tb_top;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, lock;
  logic        awready, wready, bvalid, arready, rvalid, open_l, closed_l;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, freq;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  ilim;
  int          fail_count = 0;
  int          compares = 0;

  startup_open_loop_config #(.TICK_CYCLES(8)) uut (
    .I_SYS_CLK(clk), .I_RST_N(rst_n),
    .I_AXI_AWADDR(awaddr), .I_AXI_AWVALID(awvalid), .O_AXI_AWREADY(awready),
    .I_AXI_WDATA(wdata), .I_AXI_WSTRB(wstrb), .I_AXI_WVALID(wvalid),
    .O_AXI_WREADY(wready), .O_AXI_BRESP(bresp), .O_AXI_BVALID(bvalid),
    .I_AXI_BREADY(bready), .I_AXI_ARADDR(araddr), .I_AXI_ARVALID(arvalid),
    .O_AXI_ARREADY(arready), .O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp),
    .O_AXI_RVALID(rvalid), .I_AXI_RREADY(rready), .I_OBSERVER_LOCK(lock),
    .O_OPEN_LOOP(open_l), .O_CLOSED_LOOP(closed_l),
    .O_CURRENT_LIMIT(ilim), .O_ELEC_FREQ(freq));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Bus master
  // ---------------------------------------------------------------
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 200) begin
      fail_count++;
      $display("[FAIL] handshake exp done got timeout");
      finish_test;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [1:0] r);
    int   n;
    logic aw, w, b;
    n = 0; aw = 1'b0; w = 1'b0; b = 1'b0; r = 2'b11;
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b) begin
      tick(n);
      if (!aw && awready === 1'b1) begin aw = 1'b1; awvalid <= 1'b0; end
      if (!w && wready === 1'b1) begin w = 1'b1; wvalid <= 1'b0; end
      if (bvalid === 1'b1) begin b = 1'b1; r = bresp; bready <= 1'b0; end
    end
    tick(n);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int   n;
    logic ar, got;
    n = 0; ar = 1'b0; got = 1'b0; d = '0; r = 2'b11;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!got) begin
      tick(n);
      if (!ar && arready === 1'b1) begin ar = 1'b1; arvalid <= 1'b0; end
      if (rvalid === 1'b1) begin
        got = 1'b1; d = rdata; r = rresp; rready <= 1'b0;
      end
    end
    tick(n);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(`STARTUP2_ADDR, d, r); `CHK("cfg_reset", 32'h0000_0000, d)
    `CHK("rd_resp", `RESP_OKAY, r)
    // Cap field gets code Dh: reserved cap codes are never written
    wr(`STARTUP2_ADDR, 32'hefff_ffff, 4'hf, r); `CHK("wr_resp", 2'b00, r)
    wr(`STARTUP2_ADDR, 32'h1234_5678, 4'h5, r);
    rd(`STARTUP2_ADDR, d, r); `CHK("cfg_strb", 32'hef34_ff78, d)
    wr(12'h7fc, 32'h0, 4'hf, r); `CHK("unmapped", `RESP_SLVERR, r)
    rd(`STARTUP2_ADDR, d, r); `CHK("cfg_kept", 32'hef34_ff78, d)
    rd(12'h7f8, d, r); `CHK("rd_unmapped", `RESP_SLVERR, r)
    $display("test regs done");
  endtask

  task automatic t_cap;
    logic [1:0] r;
    logic [7:0] e;
    for (int c = 0; c < 14; c++) begin
      wr(`STARTUP2_ADDR, {1'b0, 4'(c), 27'h0}, 4'hf, r);
      repeat (3) @(posedge clk);
      e = (c == 0) ? 8'h01 : (c == 1) ? 8'h02 : 8'(4 * c - 4);
      `CHK("cap", e, ilim)
    end
    wr(`CTRL_ADDR, 32'h0000_5a02, 4'hf, r);
    repeat (3) @(posedge clk);
    `CHK("general_cap", 8'h5a, ilim)
    wr(`CTRL_ADDR, 32'h0, 4'hf, r);
    $display("test cap done");
  endtask

  task automatic run_case(input logic [31:0] cfg, input logic lk,
                          input int n, input logic exp_closed);
    logic [1:0]  r;
    logic [31:0] d;
    wr(`STARTUP2_ADDR, cfg, 4'hf, r);
    lock <= lk;
    wr(`CTRL_ADDR, 32'h0000_0001, 4'hf, r);
    for (int i = 0; i < n && closed_l !== 1'b1; i++) @(posedge clk);
    `CHK("closed", exp_closed, closed_l)
    `CHK("open", !exp_closed, open_l)
    rd(`STATUS_ADDR, d, r);
    `CHK("state", exp_closed ? 32'h2 : 32'h1, d)
  endtask

  task automatic stop_run;
    logic [1:0] r;
    wr(`CTRL_ADDR, 32'h0, 4'hf, r);
    lock <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("idle", 2'b00, {open_l, closed_l})
    `CHK("idle_freq", 32'h0, freq)
    $display("test run done");
  endtask

  initial begin
    rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; lock = 1'b0; awaddr = 12'h0;
    araddr = 12'h0; wdata = 32'h0; wstrb = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_cap;
    run_case(32'h0003_e0f8, 1'b1, 40, 1'b1);
    // 50 % of the maximum speed, upper bits of the 1e-8 Hz value
    `CHK("init_freq", 32'h000b_a43b, freq)
    stop_run;
    run_case(32'h0003_e0f0, 1'b1, 40, 1'b0);
    stop_run;
    run_case(32'h0780_0000, 1'b0, 60, 1'b1);
    // One tick of the top linear coefficient reaches the 1 % threshold
    `CHK("lin_freq", 32'h0000_3b9a, freq)
    stop_run;
    run_case(32'h0784_0000, 1'b0, 60, 1'b0);
    lock <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("auto_close", 1'b1, closed_l)
    stop_run;
    finish_test;
  end
endmodule // startup_open_loop_config_tb_top

`default_nettype wire
